/* rh_desc_pkg.sv */
// Constants and types for the first root hub descriptor register.
//=============================================================================
// Overview of operation
// - Bits 31..24 hold power-good wait, counted in two millisecond units.
// - Bit 12 set disables overcurrent reporting; clear lets bit 11 choose.
// - Reset loads overcurrent mode bit 11 from the per-port switching bit.
// - Bit 11 zero is collective overcurrent, one is per port, if enabled.
// - Compound-device bit 10 always reads zero.
// - Bit 9 zero means switched ports, one means always powered.
// - Bit 8 zero gangs port power, one powers ports individually.
// - With bit 8 set, masked ports obey per-port commands only, unmasked ones global only.
// - Bits 1..0 are a read-only downstream port count, at most two.
// - Read with command 12 hex, write with command 92 hex.
// - Access is always a full 32-bit doubleword.
// - Writes are accepted only while the clock enable i_ce is high.
package rh_desc_pkg;

  //===========================================================================
  // Command codes and field positions.
  localparam logic [7:0] CMD_READ = 8'h12;
  localparam logic [7:0] CMD_WRITE = 8'h92;
  localparam int WAIT_LSB = 24;
  localparam int OC_OFF_BIT = 12;
  localparam int OC_MODE_BIT = 11;
  localparam int COMPOUND_BIT = 10;
  localparam int ALWAYS_ON_BIT = 9;
  localparam int PER_PORT_BIT = 8;
  localparam int PORT_COUNT_LSB = 0;
  localparam int NUM_PORTS = 2;

  //===========================================================================
  // Implementation-specific reset values.
  localparam logic [7:0] WAIT_RESET = 8'h32;
  localparam logic OC_OFF_RESET = 1'b0;
  localparam logic ALWAYS_ON_RESET = 1'b0;
  localparam logic PER_PORT_RESET = 1'b1;
  localparam logic [1:0] PORT_COUNT_VALUE = 2'h2;

  //===========================================================================
  // Carriers.
  typedef struct packed {
    logic [7:0] power_good_wait_time;
    logic overcurrent_report_disable;
    logic overcurrent_per_port_select;
    logic power_switching_absent;
    logic per_port_switching_select;
  } desc_fields_t;

  typedef struct packed {
    logic global_on;
    logic global_off;
    logic [NUM_PORTS-1:0] port_on;
    logic [NUM_PORTS-1:0] port_off;
  } power_cmd_t;

endpackage

/* port_power_cell.sv */
// Power state of one downstream port.
`timescale 1ns/1ps
module port_power_cell
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Mode and commands.
  input wire logic i_always_on,
  input wire logic i_individual,
  input wire logic i_mask,
  input wire logic i_global_on,
  input wire logic i_global_off,
  input wire logic i_port_on,
  input wire logic i_port_off,
  // Result.
  output logic o_power
);

  logic power_reg;
  logic use_port;

  assign use_port = i_individual && i_mask;

  //===========================================================================
  // Port power state.
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      power_reg <= 1'b0;
    else if (i_ce)
    begin
      if (i_always_on)
        power_reg <= 1'b1;
      else if (use_port)
      begin
        if (i_port_on)
          power_reg <= 1'b1;
        else if (i_port_off)
          power_reg <= 1'b0;
      end
      else
      begin
        if (i_global_on)
          power_reg <= 1'b1;
        else if (i_global_off)
          power_reg <= 1'b0;
      end
    end
  end

  assign o_power = power_reg;

endmodule // port_power_cell

/* root_hub_descriptor_first.sv */
// First root hub descriptor register with port power steering.
`timescale 1ns/1ps
module root_hub_descriptor_first
(
  // Clock, reset and enable.
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Processor command port.
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata,
  output logic o_rdata_valid,
  // Port power control from the rest of the hub.
  input wire logic [rh_desc_pkg::NUM_PORTS-1:0] i_port_power_mask,
  input wire rh_desc_pkg::power_cmd_t i_power_cmd,
  // Mode outputs.
  output rh_desc_pkg::desc_fields_t o_fields,
  output logic o_oc_reporting_on,
  output logic o_oc_per_port,
  output logic [rh_desc_pkg::NUM_PORTS-1:0] o_port_power
);

  rh_desc_pkg::desc_fields_t fields_reg;
  logic [31:0] rdata_reg;
  logic rdata_valid_reg;
  logic [31:0] image;
  logic wr_hit;
  logic rd_hit;

  assign wr_hit = i_ce && i_cmd_valid &&
    (i_cmd_code == rh_desc_pkg::CMD_WRITE);
  assign rd_hit = i_ce && i_cmd_valid &&
    (i_cmd_code == rh_desc_pkg::CMD_READ);

  //===========================================================================
  // Read image.
  always_comb
  begin
    image = 32'h0000_0000;
    image[rh_desc_pkg::WAIT_LSB +: 8] = fields_reg.power_good_wait_time;
    image[rh_desc_pkg::OC_OFF_BIT] = fields_reg.overcurrent_report_disable;
    image[rh_desc_pkg::OC_MODE_BIT] = fields_reg.overcurrent_per_port_select;
    image[rh_desc_pkg::COMPOUND_BIT] = 1'b0;
    image[rh_desc_pkg::ALWAYS_ON_BIT] = fields_reg.power_switching_absent;
    image[rh_desc_pkg::PER_PORT_BIT] = fields_reg.per_port_switching_select;
    image[rh_desc_pkg::PORT_COUNT_LSB +: 2] = rh_desc_pkg::PORT_COUNT_VALUE;
  end

  //===========================================================================
  // Writable fields.
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      fields_reg.power_good_wait_time <= rh_desc_pkg::WAIT_RESET;
      fields_reg.overcurrent_report_disable <= rh_desc_pkg::OC_OFF_RESET;
      fields_reg.overcurrent_per_port_select <= rh_desc_pkg::PER_PORT_RESET;
      fields_reg.power_switching_absent <= rh_desc_pkg::ALWAYS_ON_RESET;
      fields_reg.per_port_switching_select <= rh_desc_pkg::PER_PORT_RESET;
    end
    else if (wr_hit)
    begin
      fields_reg.power_good_wait_time <=
        i_wdata[rh_desc_pkg::WAIT_LSB +: 8];
      fields_reg.overcurrent_report_disable <=
        i_wdata[rh_desc_pkg::OC_OFF_BIT];
      fields_reg.overcurrent_per_port_select <=
        i_wdata[rh_desc_pkg::OC_MODE_BIT];
      fields_reg.power_switching_absent <=
        i_wdata[rh_desc_pkg::ALWAYS_ON_BIT];
      fields_reg.per_port_switching_select <=
        i_wdata[rh_desc_pkg::PER_PORT_BIT];
    end
  end

  //===========================================================================
  // Read answer.
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      rdata_reg <= 32'h0000_0000;
      rdata_valid_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      rdata_valid_reg <= rd_hit;
      if (rd_hit)
        rdata_reg <= image;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_rdata_valid = rdata_valid_reg;
  assign o_fields = fields_reg;

  assign o_oc_reporting_on = !fields_reg.overcurrent_report_disable;
  assign o_oc_per_port = !fields_reg.overcurrent_report_disable &&
    fields_reg.overcurrent_per_port_select;

  //===========================================================================
  // Port power cells.
  for (genvar p = 0; p < rh_desc_pkg::NUM_PORTS; p++)
  begin : g_port
    port_power_cell u_cell
    (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .i_always_on(fields_reg.power_switching_absent),
      .i_individual(fields_reg.per_port_switching_select),
      .i_mask(i_port_power_mask[p]),
      .i_global_on(i_power_cmd.global_on),
      .i_global_off(i_power_cmd.global_off),
      .i_port_on(i_power_cmd.port_on[p]),
      .i_port_off(i_power_cmd.port_off[p]),
      .o_power(o_port_power[p])
    );
  end

  //===========================================================================
  // Checks.
  property p_compound_zero;
    @(posedge i_clk) disable iff (i_reset)
    o_rdata_valid |-> (o_rdata[rh_desc_pkg::COMPOUND_BIT] == 1'b0);
  endproperty
  a_compound_zero: assert property (p_compound_zero)
    else $error("compound bit set");

  property p_port_count;
    @(posedge i_clk) disable iff (i_reset)
    o_rdata_valid |-> (o_rdata[1:0] == rh_desc_pkg::PORT_COUNT_VALUE);
  endproperty
  a_port_count: assert property (p_port_count)
    else $error("port count wrong");

  property p_reserved;
    @(posedge i_clk) disable iff (i_reset)
    o_rdata_valid |-> (o_rdata[23:13] == 11'h000 && o_rdata[7:2] == 6'h00);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved set");

  property p_read_lat;
    @(posedge i_clk) disable iff (i_reset)
    rd_hit |=> o_rdata_valid;
  endproperty
  a_read_lat: assert property (p_read_lat)
    else $error("no read answer");

  property p_ignore_other;
    @(posedge i_clk) disable iff (i_reset)
    (i_ce && i_cmd_valid && !rd_hit && !wr_hit) |=>
      (!o_rdata_valid && $stable(o_fields));
  endproperty
  a_ignore_other: assert property (p_ignore_other)
    else $error("unknown command acted on");

  property p_refused;
    @(posedge i_clk) disable iff (i_reset)
    (!i_ce && i_cmd_valid) |=> ($stable(o_fields) && $stable(o_rdata));
  endproperty
  a_refused: assert property (p_refused)
    else $error("command taken while disabled");

  property p_wait_wr;
    @(posedge i_clk) disable iff (i_reset)
    wr_hit |=> (o_fields.power_good_wait_time == $past(i_wdata[31:24]));
  endproperty
  a_wait_wr: assert property (p_wait_wr)
    else $error("wait not written");

  property p_write_modes;
    @(posedge i_clk) disable iff (i_reset)
    wr_hit |=> ((o_fields.overcurrent_report_disable ==
      $past(i_wdata[rh_desc_pkg::OC_OFF_BIT])) &&
      (o_fields.power_switching_absent ==
      $past(i_wdata[rh_desc_pkg::ALWAYS_ON_BIT])));
  endproperty
  a_write_modes: assert property (p_write_modes)
    else $error("mode bits not written");

  property p_reset_oc_mode;
    @(posedge i_clk) disable iff (i_reset)
    $past(i_reset) |-> (o_fields.overcurrent_per_port_select ==
      o_fields.per_port_switching_select);
  endproperty
  a_reset_oc_mode: assert property (p_reset_oc_mode)
    else $error("overcurrent mode reset wrong");

  property p_oc_off;
    @(posedge i_clk) disable iff (i_reset)
    o_fields.overcurrent_report_disable |->
      (!o_oc_reporting_on && !o_oc_per_port);
  endproperty
  a_oc_off: assert property (p_oc_off)
    else $error("reporting not off");

  property p_oc_mode;
    @(posedge i_clk) disable iff (i_reset)
    !o_fields.overcurrent_report_disable |->
      (o_oc_per_port == o_fields.overcurrent_per_port_select);
  endproperty
  a_oc_mode: assert property (p_oc_mode)
    else $error("overcurrent mode wrong");

  property p_always_on;
    @(posedge i_clk) disable iff (i_reset)
    (i_ce && o_fields.power_switching_absent) |=> (&o_port_power);
  endproperty
  a_always_on: assert property (p_always_on)
    else $error("ports not powered");

  property p_gang;
    @(posedge i_clk) disable iff (i_reset)
    (i_ce && !o_fields.power_switching_absent &&
     !o_fields.per_port_switching_select && i_power_cmd.global_on)
      |=> (&o_port_power);
  endproperty
  a_gang: assert property (p_gang)
    else $error("gang on failed");

  property p_mask;
    @(posedge i_clk) disable iff (i_reset)
    (i_ce && !o_fields.power_switching_absent &&
     o_fields.per_port_switching_select && i_port_power_mask[0] &&
     i_power_cmd.global_on && !i_power_cmd.port_on[0] && !o_port_power[0])
      |=> !o_port_power[0];
  endproperty
  a_mask: assert property (p_mask)
    else $error("mask ignored");

endmodule // root_hub_descriptor_first

/* host_cpu_model.sv */
// Host processor model that issues register commands.
`timescale 1ns/1ps
module host_cpu_model
(
  // Clock.
  input wire logic i_clk,
  // Register command port.
  input wire logic [31:0] i_rdata,
  input wire logic i_rdata_valid,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_code,
  output logic [31:0] o_wdata
);
  //===========================================================================
  // Command tasks.
  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd_code = 8'h00;
    o_wdata = 32'h0;
  end

  task automatic put(input logic [7:0] code, input logic [31:0] data);
    @(negedge i_clk);
    o_cmd_valid = 1'b1;
    o_cmd_code = code;
    o_wdata = data;
    @(negedge i_clk);
    o_cmd_valid = 1'b0;
    o_cmd_code = ~code;
    o_wdata = ~data;
  endtask

  task automatic write_word(input logic [31:0] data);
    put(rh_desc_pkg::CMD_WRITE, data);
  endtask

  task automatic read_word(output logic [31:0] data, output logic ok);
    put(rh_desc_pkg::CMD_READ, $urandom);
    data = i_rdata;
    ok = i_rdata_valid;
  endtask

  function automatic logic [31:0] settle_ns(input logic [7:0] wait_field);
    return 32'(wait_field) * 32'h001e8480;
  endfunction

  task automatic oc_per_port_init;
    logic [31:0] d;
    logic v;
    read_word(d, v);
    write_word(d & ~32'h00000c00);
    write_word((d | 32'h00000800) & ~32'h00000400);
  endtask
endmodule // host_cpu_model

/* root_hub_descriptor_first_bench.sv */
// Self-checking bench for the first root hub descriptor register.
`timescale 1ns/1ps
module root_hub_descriptor_first_bench;
  //===========================================================================
  // Signals and instances.
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic vld, okv, oc_on, oc_pp;
  logic [7:0] code;
  logic [31:0] wd, rd, w;
  logic [1:0] mask = 2'h1;
  logic [1:0] pwr;
  rh_desc_pkg::power_cmd_t pc = '0;
  rh_desc_pkg::desc_fields_t fld;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;

  initial
  begin
    forever #4 clk = ~clk;
  end

  root_hub_descriptor_first root_hub_descriptor_first_inst (.i_clk(clk),
    .i_reset(rst), .i_ce(ce), .i_cmd_valid(vld), .i_cmd_code(code),
    .i_wdata(wd), .o_rdata(rd), .o_rdata_valid(okv),
    .i_port_power_mask(mask), .i_power_cmd(pc), .o_fields(fld),
    .o_oc_reporting_on(oc_on), .o_oc_per_port(oc_pp), .o_port_power(pwr));

  host_cpu_model host_cpu_model_inst (.i_clk(clk), .i_rdata(rd),
    .i_rdata_valid(okv), .o_cmd_valid(vld), .o_cmd_code(code),
    .o_wdata(wd));

  //===========================================================================
  // Checking tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic read_chk(input logic [31:0] exp);
    logic [31:0] d;
    logic v;
    host_cpu_model_inst.read_word(d, v);
    check({31'h0, v}, 32'h1);
    check(d, exp);
  endtask

  task automatic pulse(input logic [5:0] c, input logic [1:0] exp);
    @(negedge clk);
    pc = c;
    @(negedge clk);
    pc = '0;
    check({30'h0, pwr}, {30'h0, exp});
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      finish_test();
    end
  end

  //===========================================================================
  // Main sequence.
  initial
  begin
    void'($urandom(32'h740f));
    repeat (20) @(negedge clk);
    rst = 1'b0;
    read_chk(32'h32000902);
    host_cpu_model_inst.write_word(32'hffffffff);
    read_chk(32'hff001b02);
    host_cpu_model_inst.oc_per_port_init();
    read_chk(32'hff001b02);
    ce = 1'b0;
    host_cpu_model_inst.write_word(32'h0);
    ce = 1'b1;
    host_cpu_model_inst.put(8'h13, 32'h0);
    read_chk(32'hff001b02);
    repeat (8)
    begin
      w = $urandom;
      host_cpu_model_inst.write_word(w);
      check({20'h0, fld}, {20'h0, w[31:24], w[12:11], w[9:8]});
      check({30'h0, oc_on, oc_pp}, {30'h0, ~w[12], ~w[12] & w[11]});
      read_chk((w & 32'hff001b00) | 32'h2);
    end
    host_cpu_model_inst.write_word(32'h32000000);
    w = host_cpu_model_inst.settle_ns(fld.power_good_wait_time);
    check(w, 32'h05f5e100);
    pulse(6'b010000, 2'b00);
    pulse(6'b100000, 2'b11);
    host_cpu_model_inst.write_word(32'h32000100);
    pulse(6'b010000, 2'b01);
    pulse(6'b000001, 2'b00);
    pulse(6'b001000, 2'b00);
    pulse(6'b100000, 2'b10);
    pulse(6'b000100, 2'b11);
    mask = 2'h2;
    pulse(6'b000010, 2'b01);
    pulse(6'b010000, 2'b00);
    host_cpu_model_inst.write_word(32'h32000200);
    pulse(6'b000000, 2'b11);
    finish_test();
  end
endmodule // root_hub_descriptor_first_bench
